//--- scl_pkg.sv
package scl_pkg;

  // ----------------------------------------------------------------
  // fuse array geometry
  // ----------------------------------------------------------------
  localparam int unsigned FUSE_BANKS = 10;
  localparam int unsigned FUSE_BITS = 26;
  localparam int unsigned FUSE_CHK = 5;
  localparam int unsigned FUSE_W = 32;
  localparam logic [3:0] LAST_BANK = 4'h9;
  // burnt fuse image: 26 data bits plus 5 check bits, values arbitrary
  // bank 0 carries one flipped data bit so a corrected load differs from a raw one
  localparam logic [31:0] FUSE_IMAGE [FUSE_BANKS] = '{
    32'h3400_00a6, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0f00_0000};
  // factory default word loaded into every trial bank, value arbitrary
  localparam logic [25:0] FACTORY_WORD = 26'h000_00c0;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] PAGE_FUNC = 2'h0;
  localparam logic [1:0] PAGE_EXT1 = 2'h1;
  localparam logic [1:0] PAGE_EXT2 = 2'h2;
  localparam logic [7:0] ADDR_DDR_REF = 8'h6a;
  localparam int unsigned DDR_REF_EN_BIT = 4;
  localparam logic DDR_REF_EN_RST = 1'h0;
  localparam logic [7:0] ADDR_TRIAL_LAST = 8'h27;
  localparam logic [7:0] ADDR_OTP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OSC_TRIM = 8'h01;
  localparam logic [7:0] ADDR_OTP_STAT = 8'h02;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam int unsigned CTRL_FUSE_LOAD_BIT = 1;
  localparam int unsigned CTRL_ECC_LOAD_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam int unsigned STYLE_BIT = 0;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned OSC16_HZ = 16_000_000;
  localparam int unsigned CLK2M_HZ = 2_000_000;
  localparam int unsigned CLK32K_HZ = 32_000;
  localparam logic [1:0] HALF_2M = 2'((OSC16_HZ / CLK2M_HZ) / 2 - 1);
  localparam logic [8:0] HALF_32K = 9'((OSC16_HZ / CLK32K_HZ) / 2 - 1);
  localparam int unsigned PB_OFF_MS = 4000;
  localparam int unsigned PB_OFF_TICKS = PB_OFF_MS * CLK32K_HZ / 1000;

  typedef enum logic [3:0] {
    SRC_NONE = 4'h1, SRC_FUSE = 4'h2, SRC_TRIAL = 4'h4, SRC_FACTORY = 4'h8
  } scl_src_t;

  typedef enum logic [3:0] {
    LD_IDLE = 4'h1, LD_CLEAR = 4'h2, LD_READ = 4'h4, LD_WRITE = 4'h8
  } scl_ld_t;

  // check bits: xor of (index+1) over every set data bit
  function automatic logic [4:0] ecc_syndrome(input logic [25:0] d);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 26; i++) begin
      if (d[i]) begin
        s = s ^ 5'(i + 1);
      end
    end
    return s;
  endfunction

  // flips the single bit that the syndrome points at
  function automatic logic [25:0] ecc_fix(input logic [31:0] w);
    logic [4:0] e;
    logic [25:0] d;
    d = w[25:0];
    e = ecc_syndrome(w[25:0]) ^ w[30:26];
    for (int i = 0; i < 26; i++) begin
      if (e == 5'(i + 1)) begin
        d[i] = ~d[i];
      end
    end
    return d;
  endfunction

endpackage

//--- scl_fuse_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scl_fuse_if;
  logic rd_en;
  logic [3:0] rd_bank;
  logic [31:0] rd_data;
  modport ctrl (output rd_en, output rd_bank, input rd_data);
  modport mem (input rd_en, input rd_bank, output rd_data);
endinterface
`default_nettype wire

//--- scl_fuse_mem.sv
`timescale 1ns/1ps
`default_nettype none
module scl_fuse_mem (
  input wire logic core_clk,
  input wire logic sys_rst,
  scl_fuse_if.mem fuse
);
  // ----------------------------------------------------------------
  // ten banks of burnt fuses, read through a register
  // ----------------------------------------------------------------
  logic [31:0] rd_q;
  wire logic [31:0] word_sel = (fuse.rd_bank <= scl_pkg::LAST_BANK)
                               ? scl_pkg::FUSE_IMAGE[fuse.rd_bank] : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_q <= 32'h0000_0000;
    end else if (fuse.rd_en) begin
      rd_q <= word_sel; // R5
    end
  end

  assign fuse.rd_data = rd_q;
endmodule
`default_nettype wire

//--- scl_startup_cfg.sv
//Contract
// R1: the start-up source is none, fuses, trial registers or factory defaults from pin and bits.
// R2: with supply valid, pin low, hold 0 and fuse-load 1, fuses are copied into trial registers.
// R3: when requested, ecc-corrected fuse values are loaded instead of raw ones.
// R4: after the fuses are loaded a later turn-on event starts up with that configuration.
// R5: fuse storage is ten banks of twenty-six bits.
// R6: trial registers sit in extended page 1, ecc control in extended page 2.
// R7: the untrimmed 32 kHz clock serves only in undervoltage, all-sleep or all-pfm; the code also uses it for irq, level-button and off-mode debounce.
// R8: the derived 32 kHz clock times start-up above undervoltage and edge-style button debounce.
// R9: in on mode with the 16 MHz running, debounce uses derived 32 kHz except the two irqs.
// R10: a 2.0 MHz clock is derived from the 16 MHz oscillator.
// R11: software may offset the 16 MHz trim in steps of 3 percent.
// R12: ddr reference control is register 0x6a with a read-write enable at bit 4 resetting to 0.
// R13: the ddr reference output follows its enable bit.
// R14: trial registers clear to zero when main supply becomes valid before any load; the code keeps them when the source is trial registers.
// R15: style 0 is a level power pin; style 1 turns on at a falling edge, off after 4 s low.
// R16: 2.0 MHz is 16 MHz divided by eight, derived 32 kHz an integer division of it.
// R17: pin and select bits are sampled at evaluation and the source holds until the next.
`timescale 1ns/1ps
`default_nettype none
module scl_startup_cfg #(
  parameter int unsigned PB_OFF_TICKS = scl_pkg::PB_OFF_TICKS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic main_supply_valid,
  input wire logic fuse_program_supply_pin,
  input wire logic input_undervoltage_threshold,
  input wire logic all_regs_sleep,
  input wire logic all_regs_pulse_frequency_switching,
  input wire logic osc16_in,
  input wire logic osc16_on,
  input wire logic osc32_raw_in,
  input wire logic on_mode,
  input wire logic power_on_pin,
  output logic clk_2m,
  output logic clk_32k_derived,
  output logic timing_clk_sel,
  output logic timing_clk,
  output logic debounce_clk,
  output logic irq_debounce_clk,
  output logic button_debounce_clk,
  output logic ddr_reference_output,
  output logic [7:0] osc_trim,
  output logic [3:0] cfg_source,
  output logic cfg_loaded,
  output logic cfg_ecc_err,
  output logic turn_on_event,
  output logic turn_off_event,
  output logic power_up_start
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [25:0] trial_q [scl_pkg::FUSE_BANKS];
  logic [2:0] ctrl_q;
  logic [7:0] trim_q;
  logic ddr_en_q;
  logic [7:0] rdata_q;
  scl_pkg::scl_src_t src_q;
  scl_pkg::scl_ld_t ld_q;
  logic [3:0] bank_q;
  logic loaded_q;
  logic ecc_err_q;
  logic sv_q;
  logic osc16_q;
  logic [1:0] cnt2m_q;
  logic [8:0] cnt32k_q;
  logic clk2m_q;
  logic clk32k_q;
  logic tsel_q;
  logic tclk_q;
  logic dclk_q;
  logic iclk_q;
  logic bclk_q;
  logic pin_q;
  logic on_q;
  logic off_q;
  logic pwr_up_q;
  logic [16:0] low_cnt_q;

  scl_fuse_if fuse ();
  scl_fuse_mem u_mem (.core_clk(core_clk), .sys_rst(sys_rst), .fuse(fuse));

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire logic hit_ddr = (reg_page == scl_pkg::PAGE_FUNC) && (reg_addr == scl_pkg::ADDR_DDR_REF);
  wire logic hit_trial = (reg_page == scl_pkg::PAGE_EXT1)
                         && (reg_addr <= scl_pkg::ADDR_TRIAL_LAST); // R6
  wire logic hit_ctrl = (reg_page == scl_pkg::PAGE_EXT2) && (reg_addr == scl_pkg::ADDR_OTP_CTRL);
  wire logic hit_trim = (reg_page == scl_pkg::PAGE_EXT2) && (reg_addr == scl_pkg::ADDR_OSC_TRIM);
  wire logic hit_stat = (reg_page == scl_pkg::PAGE_EXT2) && (reg_addr == scl_pkg::ADDR_OTP_STAT);
  wire logic [3:0] t_bank = reg_addr[5:2];
  wire logic [1:0] t_byte = reg_addr[1:0];
  wire logic [31:0] t_word = {6'h00, trial_q[t_bank]};
  wire logic [7:0] t_rd = t_word[8*t_byte +: 8];
  wire logic [7:0] rd_mux = hit_ddr ? {3'h0, ddr_en_q, 4'h0} // R12
                          : hit_trial ? t_rd
                          : hit_ctrl ? {5'h00, ctrl_q}
                          : hit_trim ? trim_q
                          : hit_stat ? {2'h0, ecc_err_q, loaded_q, src_q}
                          : 8'h00;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ddr_en_q <= scl_pkg::DDR_REF_EN_RST;
      ctrl_q <= scl_pkg::CTRL_RST;
      trim_q <= scl_pkg::TRIM_RST;
    end else if (reg_wr) begin
      if (hit_ddr) begin
        ddr_en_q <= reg_wdata[scl_pkg::DDR_REF_EN_BIT]; // R12
      end else if (hit_ctrl) begin
        ctrl_q <= reg_wdata[2:0]; // R6
      end else if (hit_trim) begin
        trim_q <= reg_wdata; // R11
      end
    end
  end

  // ----------------------------------------------------------------
  // source evaluation and loading
  // ----------------------------------------------------------------
  wire logic eval = main_supply_valid && !sv_q;
  wire logic hold_bit = ctrl_q[scl_pkg::CTRL_HOLD_BIT];
  wire logic fuse_bit = ctrl_q[scl_pkg::CTRL_FUSE_LOAD_BIT];
  wire logic ecc_bit = ctrl_q[scl_pkg::CTRL_ECC_LOAD_BIT];
  wire scl_pkg::scl_src_t src_d = fuse_program_supply_pin ? scl_pkg::SRC_FACTORY // R1
                                : hold_bit ? scl_pkg::SRC_TRIAL
                                : fuse_bit ? scl_pkg::SRC_FUSE
                                : scl_pkg::SRC_NONE;
  wire logic [25:0] fuse_word = ecc_bit ? scl_pkg::ecc_fix(fuse.rd_data)
                                        : fuse.rd_data[25:0]; // R3
  wire logic fuse_bad = (scl_pkg::ecc_syndrome(fuse.rd_data[25:0]) != fuse.rd_data[30:26]);

  assign fuse.rd_en = (ld_q == scl_pkg::LD_READ);
  assign fuse.rd_bank = bank_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sv_q <= 1'b0;
      src_q <= scl_pkg::SRC_NONE;
      ld_q <= scl_pkg::LD_IDLE;
      bank_q <= 4'h0;
      loaded_q <= 1'b0;
      ecc_err_q <= 1'b0;
    end else begin
      sv_q <= main_supply_valid;
      case (ld_q)
        scl_pkg::LD_IDLE: begin
          if (eval) begin
            src_q <= src_d; // R17
            loaded_q <= 1'b0;
            ld_q <= scl_pkg::LD_CLEAR;
          end
        end
        scl_pkg::LD_CLEAR: begin
          bank_q <= 4'h0;
          ecc_err_q <= 1'b0;
          if (src_q == scl_pkg::SRC_FUSE) begin
            ld_q <= scl_pkg::LD_READ; // R2
          end else begin
            loaded_q <= 1'b1;
            ld_q <= scl_pkg::LD_IDLE;
          end
        end
        scl_pkg::LD_READ: begin
          ld_q <= scl_pkg::LD_WRITE;
        end
        scl_pkg::LD_WRITE: begin
          ecc_err_q <= ecc_err_q | fuse_bad;
          bank_q <= bank_q + 4'h1;
          if (bank_q == scl_pkg::LAST_BANK) begin
            loaded_q <= 1'b1;
            ld_q <= scl_pkg::LD_IDLE;
          end else begin
            ld_q <= scl_pkg::LD_READ;
          end
        end
        default: begin
          ld_q <= scl_pkg::LD_IDLE;
        end
      endcase
    end
  end

  // trial bytes stay bus-writable so a held configuration can be prototyped
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int b = 0; b < scl_pkg::FUSE_BANKS; b++) begin
        trial_q[b] <= 26'h000_0000;
      end
    end else if (ld_q == scl_pkg::LD_CLEAR) begin
      for (int b = 0; b < scl_pkg::FUSE_BANKS; b++) begin
        if (src_q == scl_pkg::SRC_FACTORY) begin
          trial_q[b] <= scl_pkg::FACTORY_WORD; // R1
        end else if (src_q != scl_pkg::SRC_TRIAL) begin
          trial_q[b] <= 26'h000_0000; // R14
        end
      end
    end else if (ld_q == scl_pkg::LD_WRITE) begin
      trial_q[bank_q] <= fuse_word; // R2
    end else if (reg_wr && hit_trial) begin
      for (int k = 0; k < 26; k++) begin
        if ((k / 8) == int'(t_byte)) begin
          trial_q[t_bank][k] <= reg_wdata[k % 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // clock derivation
  // ----------------------------------------------------------------
  wire logic osc_rise = osc16_in && !osc16_q;
  wire logic tick32 = osc_rise && (cnt32k_q == scl_pkg::HALF_32K) && !clk32k_q;
  wire logic raw_sel = input_undervoltage_threshold || all_regs_sleep
                       || all_regs_pulse_frequency_switching; // R7
  wire logic style = trial_q[0][scl_pkg::STYLE_BIT];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      osc16_q <= 1'b0;
      cnt2m_q <= 2'h0;
      cnt32k_q <= 9'h000;
      clk2m_q <= 1'b0;
      clk32k_q <= 1'b0;
    end else begin
      osc16_q <= osc16_in;
      if (osc_rise) begin
        cnt2m_q <= (cnt2m_q == scl_pkg::HALF_2M) ? 2'h0 : cnt2m_q + 2'h1;
        cnt32k_q <= (cnt32k_q == scl_pkg::HALF_32K) ? 9'h000 : cnt32k_q + 9'h001;
        if (cnt2m_q == scl_pkg::HALF_2M) begin
          clk2m_q <= ~clk2m_q; // R10 R16
        end
        if (cnt32k_q == scl_pkg::HALF_32K) begin
          clk32k_q <= ~clk32k_q; // R16
        end
      end
    end
  end

  // selections are registered so no glitch reaches downstream timers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tsel_q <= 1'b0;
      tclk_q <= 1'b0;
      dclk_q <= 1'b0;
      iclk_q <= 1'b0;
      bclk_q <= 1'b0;
    end else begin
      tsel_q <= !raw_sel; // R7 R8
      tclk_q <= raw_sel ? osc32_raw_in : clk32k_q; // R8
      dclk_q <= (osc16_on && on_mode) ? clk32k_q : osc32_raw_in; // R9
      iclk_q <= osc32_raw_in; // R9
      bclk_q <= style ? clk32k_q : osc32_raw_in; // R8
    end
  end

  // ----------------------------------------------------------------
  // power button
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
      on_q <= 1'b0;
      off_q <= 1'b0;
      pwr_up_q <= 1'b0;
      low_cnt_q <= 17'h0_0000;
    end else begin
      pin_q <= power_on_pin;
      pwr_up_q <= on_q && loaded_q; // R4
      if (!style) begin
        on_q <= power_on_pin && !pin_q; // R15
        off_q <= !power_on_pin && pin_q; // R15
        low_cnt_q <= 17'h0_0000;
      end else begin
        on_q <= !power_on_pin && pin_q; // R15
        off_q <= !power_on_pin && tick32 && (low_cnt_q == 17'(PB_OFF_TICKS - 1)); // R15
        if (power_on_pin) begin
          low_cnt_q <= 17'h0_0000;
        end else if (tick32 && (low_cnt_q != 17'(PB_OFF_TICKS))) begin
          low_cnt_q <= low_cnt_q + 17'h0_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign clk_2m = clk2m_q;
  assign clk_32k_derived = clk32k_q;
  assign timing_clk_sel = tsel_q;
  assign timing_clk = tclk_q;
  assign debounce_clk = dclk_q;
  assign irq_debounce_clk = iclk_q;
  assign button_debounce_clk = bclk_q;
  assign ddr_reference_output = ddr_en_q; // R13
  assign osc_trim = trim_q; // R11
  assign cfg_source = src_q;
  assign cfg_loaded = loaded_q;
  assign cfg_ecc_err = ecc_err_q;
  assign turn_on_event = on_q;
  assign turn_off_event = off_q;
  assign power_up_start = pwr_up_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_fuse_eval;
    eval && (ld_q == scl_pkg::LD_IDLE) && !fuse_program_supply_pin && !hold_bit && fuse_bit;
  endsequence
  sequence s_loaded;
    ##[1:25] loaded_q;
  endsequence

  AST_SRC_FACTORY: assert property (eval && (ld_q == scl_pkg::LD_IDLE) // R1
    && fuse_program_supply_pin |=> src_q == scl_pkg::SRC_FACTORY)
    else $error("factory source not chosen");
  AST_FUSE_LOAD: assert property (s_fuse_eval |-> s_loaded) // R2
    else $error("fuse load did not finish");
  AST_ECC_LOAD: assert property ((ld_q == scl_pkg::LD_WRITE) && ecc_bit // R3
    |=> trial_q[$past(bank_q)] == scl_pkg::ecc_fix($past(fuse.rd_data)))
    else $error("corrected fuse word not loaded");
  AST_POWER_UP: assert property (on_q && loaded_q |=> power_up_start) // R4
    else $error("turn-on did not start power-up");
  AST_CLK2M: assert property ($changed(clk_2m) |-> $past(osc_rise) // R10
    && ($past(cnt2m_q) == scl_pkg::HALF_2M))
    else $error("2 MHz toggled off its divide point");
  AST_TSEL: assert property (raw_sel |=> !timing_clk_sel) // R7
    else $error("trimmed clock used in low-power condition");
  AST_DDR_EN: assert property (reg_wr && hit_ddr |=> // R13
    ddr_reference_output == $past(reg_wdata[scl_pkg::DDR_REF_EN_BIT]))
    else $error("ddr reference does not follow enable");
  AST_CLEAR: assert property ((ld_q == scl_pkg::LD_CLEAR) && (src_q == scl_pkg::SRC_NONE) // R14
    |=> trial_q[0] == 26'h000_0000)
    else $error("trial registers not cleared");
  AST_BTN_LEVEL: assert property (!style && power_on_pin && !pin_q |=> turn_on_event) // R15
    else $error("level power pin rise missed");
endmodule
`default_nettype wire

//--- scl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scl_host_model (
  input wire logic core_clk,
  output logic [1:0] reg_page,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------
  // register bus host
  // ----------------------------------------------------------------
  initial begin
    reg_page = 2'h3;
    reg_addr = 8'hff;
    reg_wdata = 8'hff;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released lines show the inverse, so a stale value never passes for an answer
  task automatic idle(input logic [7:0] a, input logic [7:0] d);
    reg_page = 2'h3;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_page = p;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    idle(a, d);
  endtask
  task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_page = p;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
    idle(a, 8'h00);
  endtask
endmodule
`default_nettype wire

//--- scl_startup_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scl_startup_cfg_tb;
  logic core_clk, sys_rst, osc16_in, osc32_raw_in, power_on_pin;
  logic main_supply_valid, fuse_program_supply_pin, input_undervoltage_threshold;
  logic all_regs_sleep, all_regs_pulse_frequency_switching, osc16_on, on_mode;
  logic [1:0] reg_page;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, osc_trim, d;
  logic reg_wr, reg_rd, clk_2m, clk_32k_derived, timing_clk_sel, irq_debounce_clk;
  logic timing_clk, debounce_clk, button_debounce_clk;
  logic ddr_reference_output, cfg_loaded, cfg_ecc_err;
  logic turn_on_event, turn_off_event, power_up_start;
  logic [3:0] cfg_source;
  logic [2:0] ev_w;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  assign ev_w = {power_up_start, turn_off_event, turn_on_event};

  // ----------------------------------------------------------------
  // design, host and clocks
  // ----------------------------------------------------------------
  // off-time count shortened so the button hold fits in a short run
  scl_startup_cfg #(.PB_OFF_TICKS(4)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_supply_valid(main_supply_valid),
    .fuse_program_supply_pin(fuse_program_supply_pin),
    .input_undervoltage_threshold(input_undervoltage_threshold),
    .all_regs_sleep(all_regs_sleep),
    .all_regs_pulse_frequency_switching(all_regs_pulse_frequency_switching),
    .osc16_in(osc16_in), .osc16_on(osc16_on), .osc32_raw_in(osc32_raw_in),
    .on_mode(on_mode), .power_on_pin(power_on_pin), .clk_2m(clk_2m),
    .clk_32k_derived(clk_32k_derived), .timing_clk_sel(timing_clk_sel), .timing_clk(timing_clk),
    .debounce_clk(debounce_clk), .irq_debounce_clk(irq_debounce_clk),
    .button_debounce_clk(button_debounce_clk),
    .ddr_reference_output(ddr_reference_output), .osc_trim(osc_trim),
    .cfg_source(cfg_source), .cfg_loaded(cfg_loaded), .cfg_ecc_err(cfg_ecc_err),
    .turn_on_event(turn_on_event), .turn_off_event(turn_off_event),
    .power_up_start(power_up_start));
  scl_host_model host_u (.core_clk(core_clk), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    #1;
    osc16_in = ~osc16_in;
  end
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      $display("ERROR t=%0t timeout got=%h exp=%h", $time, cyc, 0);
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // compares and helpers
  // ----------------------------------------------------------------
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_ev(input int idx, input int lim, output int c);
    c = 0;
    while (ev_w[idx] !== 1'b1 && c < lim) begin
      tick(1);
      c++;
    end
  endtask
  // cycles between two toggles of the chosen derived clock
  task automatic wait_tog(input bit sel, output int c);
    logic p;
    for (int k = 0; k < 2; k++) begin
      p = sel ? clk_32k_derived : clk_2m;
      c = 0;
      while ((sel ? clk_32k_derived : clk_2m) === p && c < 2000) begin
        tick(1);
        c++;
      end
    end
  endtask
  // supply rise with given pin and control bits; the source must then hold
  task automatic eval(input logic pin, input logic [7:0] ctrl, input logic [3:0] src);
    host_u.wr(scl_pkg::PAGE_EXT2, scl_pkg::ADDR_OTP_CTRL, ctrl);
    fuse_program_supply_pin = pin;
    main_supply_valid = 1'b0;
    tick(1);
    main_supply_valid = 1'b1;
    wait_ev(0, 2, n);
    n = 0;
    while (cfg_loaded !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk_v({4'h0, cfg_source}, {4'h0, src});
    host_u.rd(scl_pkg::PAGE_EXT2, scl_pkg::ADDR_OTP_STAT, d);
    chk_v(d, {2'h0, src == scl_pkg::SRC_FUSE, 1'b1, src});
    fuse_program_supply_pin = ~pin;
    tick(3);
    chk_v({4'h0, cfg_source}, {4'h0, src});
    fuse_program_supply_pin = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ddr_ref;
    host_u.rd(2'h0, scl_pkg::ADDR_DDR_REF, d);
    chk_v(d, 8'h00);
    chk_v({7'h0, ddr_reference_output}, 8'h00);
    host_u.wr(2'h0, scl_pkg::ADDR_DDR_REF, 8'hff);
    chk_v({7'h0, ddr_reference_output}, 8'h01);
    host_u.rd(2'h0, scl_pkg::ADDR_DDR_REF, d);
    chk_v(d, 8'h10);
    host_u.rd(2'h0, 8'h6b, d);
    chk_v(d, 8'h00);
    host_u.wr(2'h0, scl_pkg::ADDR_DDR_REF, 8'hef);
    chk_v({7'h0, ddr_reference_output}, 8'h00);
    host_u.rd(2'h0, scl_pkg::ADDR_DDR_REF, d);
    chk_v(d, 8'h00);
    host_u.wr(scl_pkg::PAGE_EXT2, scl_pkg::ADDR_OSC_TRIM, 8'hfd);
    chk_v(osc_trim, 8'hfd);
  endtask
  task automatic t_source;
    host_u.wr(scl_pkg::PAGE_EXT1, 8'h00, 8'h5a);
    host_u.wr(scl_pkg::PAGE_EXT1, scl_pkg::ADDR_TRIAL_LAST, 8'hff);
    host_u.rd(scl_pkg::PAGE_EXT1, scl_pkg::ADDR_TRIAL_LAST, d);
    chk_v(d, 8'h03);
    eval(1'b0, 8'h01, scl_pkg::SRC_TRIAL);
    eval(1'b0, 8'h03, scl_pkg::SRC_TRIAL);
    host_u.rd(scl_pkg::PAGE_EXT1, 8'h00, d);
    chk_v(d, 8'h5a);
    eval(1'b0, 8'h02, scl_pkg::SRC_FUSE);
    host_u.rd(scl_pkg::PAGE_EXT1, 8'h00, d);
    chk_v(d, scl_pkg::FUSE_IMAGE[0][7:0]);
    host_u.rd(scl_pkg::PAGE_EXT1, scl_pkg::ADDR_TRIAL_LAST, d);
    chk_v(d, {6'h0, scl_pkg::FUSE_IMAGE[9][25:24]});
    host_u.wr(scl_pkg::PAGE_EXT1, 8'h00, 8'h5a);
    eval(1'b0, 8'h06, scl_pkg::SRC_FUSE);
    host_u.rd(scl_pkg::PAGE_EXT1, 8'h00, d);
    // bank 0 byte with its flipped bit put back
    chk_v(d, 8'ha4);
    chk_v({7'h0, cfg_ecc_err}, 8'h01);
    host_u.wr(scl_pkg::PAGE_EXT1, 8'h00, 8'h5a);
    eval(1'b0, 8'h00, scl_pkg::SRC_NONE);
    host_u.rd(scl_pkg::PAGE_EXT1, 8'h00, d);
    chk_v(d, 8'h00);
    host_u.wr(scl_pkg::PAGE_EXT1, 8'h00, 8'h5a);
    eval(1'b1, 8'h01, scl_pkg::SRC_FACTORY);
    host_u.rd(scl_pkg::PAGE_EXT1, 8'h00, d);
    chk_v(d, scl_pkg::FACTORY_WORD[7:0]);
  endtask
  task automatic t_clocks;
    wait_tog(1'b0, n);
    chk_n(n, 8);
    wait_tog(1'b1, n);
    chk_n(n, 500);
    for (int i = 0; i < 4; i++) begin
      input_undervoltage_threshold = (i == 1);
      all_regs_sleep = (i == 2);
      all_regs_pulse_frequency_switching = (i == 3);
      tick(2);
      chk_v({7'h0, timing_clk_sel}, 8'(i == 0));
    end
    // off mode, level button and all-pfm: every mux falls back to the untrimmed clock
    on_mode = 1'b0;
    osc32_raw_in = 1'b1;
    tick(3);
    chk_v({4'h0, timing_clk, debounce_clk, button_debounce_clk, irq_debounce_clk}, 8'h0f);
    osc32_raw_in = 1'b0;
    tick(3);
    chk_v({4'h0, timing_clk, debounce_clk, button_debounce_clk, irq_debounce_clk}, 8'h00);
  endtask
  task automatic t_button;
    host_u.wr(scl_pkg::PAGE_EXT1, 8'h00, 8'h00);
    power_on_pin = 1'b1;
    wait_ev(0, 10, n);
    chk_n(int'(n < 10), 1);
    wait_ev(2, 3, n);
    chk_n(int'(n < 3), 1);
    power_on_pin = 1'b0;
    wait_ev(1, 10, n);
    chk_n(int'(n < 10), 1);
    host_u.wr(scl_pkg::PAGE_EXT1, 8'h00, 8'h01);
    power_on_pin = 1'b1;
    tick(3);
    power_on_pin = 1'b0;
    wait_ev(0, 10, n);
    chk_n(int'(n < 10), 1);
    tick(1);
    wait_ev(1, 1000, n);
    chk_n(n, 1000);
    wait_ev(1, 20000, n);
    chk_n(int'(n < 20000), 1);
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    osc16_in = 1'b0;
    osc32_raw_in = 1'b0;
    power_on_pin = 1'b0;
    main_supply_valid = 1'b0;
    fuse_program_supply_pin = 1'b0;
    input_undervoltage_threshold = 1'b0;
    all_regs_sleep = 1'b0;
    all_regs_pulse_frequency_switching = 1'b0;
    osc16_on = 1'b1;
    on_mode = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    chk_v({4'h0, cfg_source}, 8'h01);
    main_supply_valid = 1'b1;
    tick(4);
    t_ddr_ref;
    t_source;
    t_clocks;
    t_button;
    final_report;
  end
endmodule
`default_nettype wire
